// file: core/jtsr_pkg.sv
package jtsr_pkg;

  // ----------------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------------
  localparam int unsigned JTSR_IR_W = 16;
  localparam logic [31:0] JTSR_IR_ADDR = 32'h0400_0200;
  localparam logic [15:0] JTSR_IR_RESET = 16'hFFFF;
  // Ones in the reserved bits, 01 in the two lowest as the standard asks.
  localparam logic [15:0] JTSR_IR_CAPTURE = 16'hFFFD;
  localparam logic [11:0] JTSR_IR_RSVD = 12'hFFF;
  localparam int unsigned JTSR_CMD_MSB = 15;
  localparam int unsigned JTSR_CMD_LSB = 12;

  // ----------------------------------------------------------------------
  // Command codes of the command field
  // ----------------------------------------------------------------------
  localparam logic [3:0] JTSR_CMD_EXTEST = 4'h0;
  localparam logic [3:0] JTSR_CMD_SAMPLE = 4'h4;
  localparam logic [3:0] JTSR_CMD_RST_NEG = 4'h6;
  localparam logic [3:0] JTSR_CMD_RST_ASR = 4'h7;
  localparam logic [2:0] JTSR_CMD_INTR_HI = 3'h5;
  localparam logic [3:0] JTSR_CMD_WAKE = 4'h1;
  localparam logic [3:0] JTSR_CMD_BYPASS = 4'hF;

  // ----------------------------------------------------------------------
  // Pin scan chain layout, cell 338 sits nearest the serial input
  // ----------------------------------------------------------------------
  localparam int unsigned JTSR_CHAIN_LEN = 339;
  localparam int unsigned JTSR_DBUS_IN_MSB = 338;
  localparam int unsigned JTSR_DBUS_OUT_MSB = 298;
  localparam int unsigned JTSR_DBUS_CTL_MSB = 266;
  localparam int unsigned JTSR_DBUS_W = 32;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    JTSR_TLR = 4'h0, JTSR_RTI = 4'h1, JTSR_SDR = 4'h3, JTSR_CDR = 4'h2,
    JTSR_SHDR = 4'h6, JTSR_E1DR = 4'h7, JTSR_PDR = 4'h5, JTSR_E2DR = 4'h4,
    JTSR_UDR = 4'hC, JTSR_SIR = 4'hD, JTSR_CIR = 4'hF, JTSR_SHIR = 4'hE,
    JTSR_E1IR = 4'hA, JTSR_PIR = 4'hB, JTSR_E2IR = 4'h9, JTSR_UIR = 4'h8
  } jtsr_state_t;

  typedef enum logic [2:0] {
    JTSR_K_EXTEST, JTSR_K_SAMPLE, JTSR_K_RST_NEG, JTSR_K_RST_ASR,
    JTSR_K_INTR, JTSR_K_WAKE, JTSR_K_BYPASS, JTSR_K_RSVD
  } jtsr_kind_t;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Sorts a four-bit command into the action it asks for.
  function automatic jtsr_kind_t jtsr_decode(input logic [3:0] cmd);
    jtsr_kind_t k;
    k = JTSR_K_RSVD;
    if (cmd == JTSR_CMD_EXTEST) k = JTSR_K_EXTEST;
    else if (cmd == JTSR_CMD_SAMPLE) k = JTSR_K_SAMPLE;
    else if (cmd == JTSR_CMD_RST_NEG) k = JTSR_K_RST_NEG;
    else if (cmd == JTSR_CMD_RST_ASR) k = JTSR_K_RST_ASR;
    else if (cmd[3:1] == JTSR_CMD_INTR_HI) k = JTSR_K_INTR;
    else if (cmd == JTSR_CMD_WAKE) k = JTSR_K_WAKE;
    else if (cmd == JTSR_CMD_BYPASS) k = JTSR_K_BYPASS;
    return k;
  endfunction

  // Standard sixteen-state controller step for one mode-select sample.
  function automatic jtsr_state_t jtsr_step(input jtsr_state_t s,
                                            input logic tms);
    jtsr_state_t n;
    n = JTSR_TLR;
    case (s)
      JTSR_TLR: n = tms ? JTSR_TLR : JTSR_RTI;
      JTSR_RTI: n = tms ? JTSR_SDR : JTSR_RTI;
      JTSR_SDR: n = tms ? JTSR_SIR : JTSR_CDR;
      JTSR_CDR: n = tms ? JTSR_E1DR : JTSR_SHDR;
      JTSR_SHDR: n = tms ? JTSR_E1DR : JTSR_SHDR;
      JTSR_E1DR: n = tms ? JTSR_UDR : JTSR_PDR;
      JTSR_PDR: n = tms ? JTSR_E2DR : JTSR_PDR;
      JTSR_E2DR: n = tms ? JTSR_UDR : JTSR_SHDR;
      JTSR_UDR: n = tms ? JTSR_SDR : JTSR_RTI;
      JTSR_SIR: n = tms ? JTSR_TLR : JTSR_CIR;
      JTSR_CIR: n = tms ? JTSR_E1IR : JTSR_SHIR;
      JTSR_SHIR: n = tms ? JTSR_E1IR : JTSR_SHIR;
      JTSR_E1IR: n = tms ? JTSR_UIR : JTSR_PIR;
      JTSR_PIR: n = tms ? JTSR_E2IR : JTSR_PIR;
      JTSR_E2IR: n = tms ? JTSR_UIR : JTSR_SHIR;
      JTSR_UIR: n = tms ? JTSR_SDR : JTSR_RTI;
      default: n = JTSR_TLR;
    endcase
    return n;
  endfunction

endpackage

// file: core/jtsr_scan_if.sv
`timescale 1ns/10ps
`default_nettype none
// Strobes from the controller to the pin scan chain and its serial output.
interface jtsr_scan_if;
  logic capture;
  logic shift;
  logic update;
  logic si;
  logic so;
  modport ctl (output capture, output shift, output update, output si,
               input so);
  modport chain (input capture, input shift, input update, input si,
                 output so);
endinterface
`default_nettype wire

// file: core/jtsr_bscan.sv
`timescale 1ns/10ps
`default_nettype none
module jtsr_bscan
  import jtsr_pkg::*;
#(
  parameter int unsigned CHAIN_LEN = JTSR_CHAIN_LEN
) (
  // Clock, reset and enable.
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Controller side.
  jtsr_scan_if.chain scan,
  // Pad side.
  input wire logic [CHAIN_LEN-1:0] i_pad_in,
  output logic [CHAIN_LEN-1:0] o_pad_out
);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  if (CHAIN_LEN < 2) begin : g_bad_len
    $error("jtsr_bscan: chain needs at least two cells");
  end

  // ----------------------------------------------------------------------
  // Shift stage and update stage
  // ----------------------------------------------------------------------
  logic [CHAIN_LEN-1:0] shift_q;
  logic [CHAIN_LEN-1:0] shift_d;
  logic [CHAIN_LEN-1:0] upd_q;
  logic [CHAIN_LEN-1:0] upd_d;

  // Serial data enters at the top cell and leaves from cell zero.
  always_comb begin
    shift_d = shift_q;
    upd_d = upd_q;
    if (scan.capture) begin
      shift_d = i_pad_in;
    end else if (scan.shift) begin
      shift_d = {scan.si, shift_q[CHAIN_LEN-1:1]};
    end
    if (scan.update) begin
      upd_d = shift_q;
    end
  end

  // The shift stage carries no reset: its content is undefined until the
  // host captures or shifts, and this saves a wide reset net.
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      shift_q <= shift_d;
    end
    if (i_reset) begin
      upd_q <= '0;
    end else if (i_ce) begin
      upd_q <= upd_d;
    end
  end

  assign scan.so = shift_q[0];
  assign o_pad_out = upd_q;

endmodule
`default_nettype wire

// file: core/jtsr_tap.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - A one-bit bypass cell, hidden from the CPU, sits between serial in and out under the bypass command.
// - The 16-bit instruction register reads at 0x04000200 and CPU writes never change it.
// - The serial port can load the instruction register at any time, whatever the CPU is doing.
// - The instruction register becomes 0xFFFF while test reset is low or the controller is in reset state.
// - After reset the command field holds all ones, which selects bypass.
// - Command field codes decode to external test, sample/preload, reset negate/assert, interrupt, wake, bypass.
// - Instruction bits 11 to 0 always read as one.
// - The pin scan chain is a shift register of pad cells that observe and control the pins.
// - External test and sample/preload put the pin scan chain between serial in and out.
// - The chain counts down from cell 338 next to serial in, with fixed input, output and enable cells.
// - Chain shift contents are undefined after reset; the bypass cell and chain outputs clear to zero and the instruction register is set.
// - Test reset acts independently of the test clock and holds the port in reset while low.
// - Serial input and mode select are taken with the test clock and serial output follows it.
// - The controller steps through the standard sixteen states on each sampled mode-select bit.
module jtsr_tap
  import jtsr_pkg::*;
#(
  parameter int unsigned CHAIN_LEN = JTSR_CHAIN_LEN
) (
  // Clock, reset and enable.
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Test access pins.
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_trst_n,
  output logic o_tdo,
  output logic o_tdo_oe,
  // CPU read port.
  input wire logic [31:0] i_cpu_addr,
  input wire logic i_cpu_rd,
  input wire logic i_cpu_wr,
  output logic [15:0] o_cpu_rdata,
  output logic o_cpu_ack,
  // Pad ring.
  input wire logic [CHAIN_LEN-1:0] i_pad_in,
  output logic [CHAIN_LEN-1:0] o_pad_out,
  output logic o_extest,
  // Requests to the CPU side.
  output logic o_dbg_reset,
  output logic o_dbg_irq,
  output logic o_wake
);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  if (CHAIN_LEN <= JTSR_DBUS_IN_MSB) begin : g_bad_len
    $error("jtsr_tap: chain too short for the data bus cells");
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Bit order: 3 test reset, 2 clock, 1 mode select, 0 serial in.
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic tck_prev_q;
  logic trst_n_s;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_rise;
  logic tck_fall;

  // Only the second stage is ever read; the first one just settles.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      tck_prev_q <= 1'b0;
    end else if (i_ce) begin
      pin_s1_q <= {i_trst_n, i_tck, i_tms, i_tdi};
      pin_s2_q <= pin_s1_q;
      tck_prev_q <= pin_s2_q[2];
    end
  end

  // All pins share the same delay, so mode select and serial in stay
  // aligned with the clock edges found here.
  assign trst_n_s = pin_s2_q[3];
  assign tck_s = pin_s2_q[2];
  assign tms_s = pin_s2_q[1];
  assign tdi_s = pin_s2_q[0];
  assign tck_rise = tck_s & ~tck_prev_q;
  assign tck_fall = ~tck_s & tck_prev_q;

  // ----------------------------------------------------------------------
  // Controller, instruction register, bypass cell, serial output
  // ----------------------------------------------------------------------
  jtsr_state_t st_q;
  jtsr_state_t st_d;
  logic [15:0] ir_sh_q;
  logic [15:0] ir_sh_d;
  logic [15:0] ir_q;
  logic [15:0] ir_d;
  logic byp_q;
  logic byp_d;
  logic tdo_q;
  logic tdo_d;
  logic oe_q;
  logic oe_d;
  logic rst_req_q;
  logic rst_req_d;
  logic irq_q;
  logic irq_d;
  logic wake_q;
  logic wake_d;
  logic extest_q;
  logic extest_d;
  jtsr_kind_t cur_kind;
  jtsr_kind_t new_kind;
  logic sel_chain;

  jtsr_scan_if scan ();

  assign cur_kind = jtsr_decode(ir_q[JTSR_CMD_MSB:JTSR_CMD_LSB]);
  assign new_kind = jtsr_decode(ir_sh_q[JTSR_CMD_MSB:JTSR_CMD_LSB]);
  // Reserved codes fall onto the bypass path, a harmless choice.
  assign sel_chain = (cur_kind == JTSR_K_EXTEST) ||
                     (cur_kind == JTSR_K_SAMPLE);

  // Chain strobes: capture and shift on the rising test clock, update on
  // the falling one, as the standard places them.
  assign scan.capture = tck_rise && sel_chain && (st_q == JTSR_CDR);
  assign scan.shift = tck_rise && sel_chain && (st_q == JTSR_SHDR);
  assign scan.update = tck_fall && sel_chain && (st_q == JTSR_UDR);
  assign scan.si = tdi_s;

  always_comb begin
    st_d = st_q;
    ir_sh_d = ir_sh_q;
    ir_d = ir_q;
    byp_d = byp_q;
    tdo_d = tdo_q;
    oe_d = oe_q;
    rst_req_d = rst_req_q;
    irq_d = 1'b0;
    wake_d = 1'b0;
    extest_d = extest_q;
    if (!trst_n_s) begin
      // Test reset is sampled by the system clock, never by the test
      // clock, so it works with the test clock stopped.
      st_d = JTSR_TLR;
      ir_d = JTSR_IR_RESET;
      oe_d = 1'b0;
      rst_req_d = 1'b0;
      extest_d = 1'b0;
    end else begin
      if (tck_rise) begin
        st_d = jtsr_step(st_q, tms_s);
        case (st_q)
          JTSR_CIR: begin
            ir_sh_d = JTSR_IR_CAPTURE;
          end
          JTSR_SHIR: begin
            ir_sh_d = {tdi_s, ir_sh_q[15:1]};
          end
          JTSR_CDR: begin
            if (!sel_chain) byp_d = 1'b0;
          end
          JTSR_SHDR: begin
            if (!sel_chain) byp_d = tdi_s;
          end
          default: begin
          end
        endcase
      end
      if (tck_fall) begin
        case (st_q)
          JTSR_SHIR: begin
            tdo_d = ir_sh_q[0];
            oe_d = 1'b1;
          end
          JTSR_SHDR: begin
            tdo_d = sel_chain ? scan.so : byp_q;
            oe_d = 1'b1;
          end
          JTSR_UIR: begin
            oe_d = 1'b0;
            // Reserved low bits are forced to one on every load.
            ir_d = {ir_sh_q[JTSR_CMD_MSB:JTSR_CMD_LSB], JTSR_IR_RSVD};
            extest_d = (new_kind == JTSR_K_EXTEST);
            case (new_kind)
              JTSR_K_RST_ASR: rst_req_d = 1'b1;
              JTSR_K_RST_NEG: rst_req_d = 1'b0;
              JTSR_K_INTR: irq_d = 1'b1;
              JTSR_K_WAKE: wake_d = 1'b1;
              default: begin
              end
            endcase
          end
          default: begin
            oe_d = 1'b0;
          end
        endcase
      end
      if (st_q == JTSR_TLR) begin
        ir_d = JTSR_IR_RESET;
        rst_req_d = 1'b0;
        extest_d = 1'b0;
      end
    end
  end

  // The bypass cell is cleared on reset only to keep simulation clean;
  // the host must not rely on its value before a capture.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_q <= JTSR_TLR;
      ir_sh_q <= JTSR_IR_RESET;
      ir_q <= JTSR_IR_RESET;
      byp_q <= 1'b0;
      tdo_q <= 1'b0;
      oe_q <= 1'b0;
      rst_req_q <= 1'b0;
      irq_q <= 1'b0;
      wake_q <= 1'b0;
      extest_q <= 1'b0;
    end else if (i_ce) begin
      st_q <= st_d;
      ir_sh_q <= ir_sh_d;
      ir_q <= ir_d;
      byp_q <= byp_d;
      tdo_q <= tdo_d;
      oe_q <= oe_d;
      rst_req_q <= rst_req_d;
      irq_q <= irq_d;
      wake_q <= wake_d;
      extest_q <= extest_d;
    end
  end

  // ----------------------------------------------------------------------
  // CPU read port
  // ----------------------------------------------------------------------
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic ack_q;
  logic ack_d;

  // Writes are acknowledged but dropped; unmapped reads return zero.
  always_comb begin
    ack_d = i_cpu_rd | i_cpu_wr;
    rdata_d = 16'h0000;
    if (i_cpu_rd && (i_cpu_addr == JTSR_IR_ADDR)) begin
      rdata_d = ir_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
    end else if (i_ce) begin
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

  // ----------------------------------------------------------------------
  // Pin scan chain
  // ----------------------------------------------------------------------
  jtsr_bscan #(
    .CHAIN_LEN(CHAIN_LEN)
  ) u_bscan (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .scan(scan.chain),
    .i_pad_in(i_pad_in),
    .o_pad_out(o_pad_out)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_tdo = tdo_q;
  assign o_tdo_oe = oe_q;
  assign o_cpu_rdata = rdata_q;
  assign o_cpu_ack = ack_q;
  assign o_extest = extest_q;
  assign o_dbg_reset = rst_req_q;
  assign o_dbg_irq = irq_q;
  assign o_wake = wake_q;

endmodule
`default_nettype wire

// file: testbench/jtsr_tap_props.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
// Watches the top ports only. The clock enable is held high by the bench.
module jtsr_tap_props
  import jtsr_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // Test access pins.
  input wire logic i_tck,
  input wire logic i_trst_n,
  input wire logic o_tdo,
  input wire logic o_tdo_oe,
  // CPU read port.
  input wire logic [31:0] i_cpu_addr,
  input wire logic i_cpu_rd,
  input wire logic i_cpu_wr,
  input wire logic [15:0] o_cpu_rdata,
  input wire logic o_cpu_ack,
  // Requests.
  input wire logic o_extest,
  input wire logic o_dbg_reset,
  input wire logic o_dbg_irq,
  input wire logic o_wake
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // Every taken access, and only those, is answered one cycle later.
  ack_match_a: assert property (
    o_cpu_ack == $past(i_ce && (i_cpu_rd || i_cpu_wr)))
    else $error("Acknowledge does not follow the access.");
  rsvd_bits_a: assert property (
    i_ce && i_cpu_rd && i_cpu_addr == JTSR_IR_ADDR
    |=> o_cpu_rdata[11:0] == JTSR_IR_RSVD)
    else $error("Low instruction bits did not read as ones.");
  unmapped_zero_a: assert property (
    i_ce && i_cpu_rd && i_cpu_addr != JTSR_IR_ADDR
    |=> o_cpu_rdata == 16'h0000)
    else $error("Unmapped read returned data.");
  rdata_idle_a: assert property (
    !o_cpu_ack |-> o_cpu_rdata == 16'h0000)
    else $error("Read data shown without acknowledge.");
  // Six cycles covers the two-flop synchroniser and the output flop.
  trst_reset_a: assert property (
    !i_trst_n [*6] |-> !o_dbg_reset && !o_extest && !o_tdo_oe)
    else $error("Test reset did not clear the port.");
  irq_pulse_a: assert property (
    o_dbg_irq |=> !o_dbg_irq)
    else $error("Interrupt request longer than one cycle.");
  wake_pulse_a: assert property (
    o_wake |=> !o_wake)
    else $error("Wake request longer than one cycle.");
  // Serial output may only move after a test clock fall has been seen.
  tdo_on_fall_a: assert property (
    $changed(o_tdo) |-> !$past(i_tck, 2))
    else $error("Serial output moved while test clock was high.");
endmodule
`default_nettype wire

// file: testbench/jtsr_host.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Test host model
// ----------------------------------------------------------------------
// The test clock stands low between operations; pins move at the
// falling system clock edge, well clear of the device's sampling.
module jtsr_host (
  // System clock for pacing.
  input wire logic i_clk,
  // Test access pins.
  input wire logic i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_n
);
  // Pins idle with the clock low and the test reset released.
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    o_trst_n = 1'b1;
  end

  // One test clock of 8 system clocks. The bit returned is the one the
  // device showed before this fall, that is, the bit it shifted out.
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    repeat (4) @(negedge i_clk);
    o_tck = 1'b1;
    repeat (4) @(negedge i_clk);
    tdo = i_tdo;
    o_tck = 1'b0;
  endtask

  // Five ones reach reset state from anywhere, then park in idle.
  task automatic tlr();
    logic b;
    repeat (5) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask

  // Full scan from idle back to idle, LSB first; only legal codes are
  // ever handed in by the bench.
  task automatic scan(input logic ir, input int n, input logic [338:0] din,
                      output logic [338:0] dout);
    logic b;
    dout = '1;
    step(1'b1, 1'b0, b);
    if (ir) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask

  // Test reset pulse with the test clock held low.
  task automatic trst();
    o_trst_n = 1'b0;
    repeat (8) @(negedge i_clk);
    o_trst_n = 1'b1;
    repeat (4) @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_jtsr_tap.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------
module tb_jtsr_tap;
  import jtsr_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] addr = '0;
  logic [338:0] pad_in = '0;
  logic [338:0] pad_out, din, o;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, ack, extest, dbg_reset;
  logic dbg_irq, wake, rst_m, tdo_line;
  logic [15:0] rdata, ir_m;
  int miscompares = 0;
  int checked = 0;
  int irq_n = 0;
  int wake_n = 0;
  int irq_m = 0;
  int wake_m = 0;
  logic [3:0] codes [8] = '{4'h0, 4'h4, 4'h6, 4'h7, 4'hA, 4'hB, 4'h1, 4'hF};
  logic [3:0] chain_codes [2] = '{4'h4, 4'h0};

  // 25 MHz system clock.
  always #20 clk = ~clk;

  // A released serial output shows the inverse of its last bit, so a
  // sample taken outside the shift window cannot pass by accident.
  assign tdo_line = tdo_oe ? tdo : ~tdo;

  jtsr_host host_u (.i_clk(clk), .i_tdo(tdo_line), .o_tck(tck), .o_tms(tms),
    .o_tdi(tdi), .o_trst_n(trst_n));

  jtsr_tap dut_u (
    .i_clk(clk), .i_reset(reset), .i_ce(1'b1), .i_tck(tck), .i_tms(tms),
    .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe(tdo_oe),
    .i_cpu_addr(addr), .i_cpu_rd(rd), .i_cpu_wr(wr), .o_cpu_rdata(rdata),
    .o_cpu_ack(ack), .i_pad_in(pad_in), .o_pad_out(pad_out),
    .o_extest(extest), .o_dbg_reset(dbg_reset), .o_dbg_irq(dbg_irq),
    .o_wake(wake));

  // Interrupt and wake requests are one-cycle pulses, so they are tallied
  // at every falling edge, where they have settled.
  always @(negedge clk) begin
    if (dbg_irq === 1'b1) irq_n++;
    if (wake === 1'b1) wake_n++;
  end

  task automatic chk(input logic [338:0] got, input logic [338:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // One CPU access; the answer is looked at in its single ack cycle.
  task automatic cpu(input logic [31:0] a, input logic w,
                     input logic [15:0] exp);
    @(negedge clk);
    addr = a;
    rd = !w;
    wr = w;
    @(negedge clk);
    chk(ack, 1'b1);
    if (!w) chk(rdata, exp);
    rd = 1'b0;
    wr = 1'b0;
  endtask

  // Loads a command and checks every side effect against the model.
  task automatic load(input logic [3:0] c);
    logic [338:0] q;
    host_u.scan(1'b1, 16, {323'h0, c, JTSR_IR_RSVD}, q);
    ir_m = {c, 12'hFFF};
    if (c == 4'h7) rst_m = 1'b1;
    if (c == 4'h6) rst_m = 1'b0;
    if (c[3:1] == 3'h5) irq_m++;
    if (c == 4'h1) wake_m++;
    repeat (4) @(negedge clk);
    chk(q[15:0], JTSR_IR_CAPTURE);
    cpu(JTSR_IR_ADDR, 1'b0, ir_m);
    chk(extest, c == 4'h0);
    chk(dbg_reset, rst_m);
    chk(irq_n, irq_m);
    chk(wake_n, wake_m);
  endtask

  // Main sequence.
  initial begin
    rst_m = 1'b0;
    void'($urandom(48880));
    repeat (10) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    cpu(JTSR_IR_ADDR, 1'b0, JTSR_IR_RESET);
    cpu(JTSR_IR_ADDR, 1'b1, 16'h0000);
    cpu(JTSR_IR_ADDR, 1'b0, JTSR_IR_RESET);
    cpu(JTSR_IR_ADDR + 32'h2, 1'b0, 16'h0000);
    $display("test cpu_reads done");
    host_u.tlr();
    foreach (codes[k]) load(codes[k]);
    $display("test commands done");
    for (int i = 0; i < 339; i++) din[i] = 1'($urandom);
    host_u.scan(1'b0, 8, din, o);
    chk(o[7:0], {din[6:0], 1'b0});
    $display("test bypass done");
    foreach (chain_codes[k]) begin
      load(chain_codes[k]);
      for (int i = 0; i < 339; i++) begin
        pad_in[i] = 1'($urandom);
        din[i] = 1'($urandom);
      end
      host_u.scan(1'b0, 339, din, o);
      repeat (6) @(negedge clk);
      chk(o, pad_in);
      chk(pad_out, din);
    end
    $display("test pin_chain done");
    load(4'h7);
    host_u.tlr();
    rst_m = 1'b0;
    cpu(JTSR_IR_ADDR, 1'b0, JTSR_IR_RESET);
    chk(dbg_reset, rst_m);
    load(4'h7);
    host_u.trst();
    cpu(JTSR_IR_ADDR, 1'b0, JTSR_IR_RESET);
    chk(dbg_reset, 1'b0);
    $display("test resets done");
    close_out();
  end

  // Watchdog: the run needs well under half of this span.
  initial begin
    #2000000;
    miscompares++;
    close_out();
  end
endmodule

bind jtsr_tap jtsr_tap_props props_u (
  .i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_tck(i_tck),
  .i_trst_n(i_trst_n), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
  .i_cpu_addr(i_cpu_addr), .i_cpu_rd(i_cpu_rd), .i_cpu_wr(i_cpu_wr),
  .o_cpu_rdata(o_cpu_rdata), .o_cpu_ack(o_cpu_ack), .o_extest(o_extest),
  .o_dbg_reset(o_dbg_reset), .o_dbg_irq(o_dbg_irq), .o_wake(o_wake));
`default_nettype wire
